// >>> core/pasw_pkg.sv
// ****************************************
// Register map and constants
// ****************************************
package pasw_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] OFF_ANALOG_SELECT = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_POWER_CONTROL = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_PORT_PINS = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_PORT_DIRECTION = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_INT_FLAG_TWO = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_INT_ENABLE_TWO = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_INT_CONTROL = 8'h18;
    // Field positions
    localparam int POWER_CONTROL_WAKE_EN_BIT = 5;
    localparam int POWER_CONTROL_SW_BOR_BIT = 4;
    localparam int FLAG_WAKE_BIT = 6;
    localparam int INT_CONTROL_GLOBAL_BIT = 7;
    localparam int INT_CONTROL_PERIPH_BIT = 6;
    localparam int OSC_PIN_HI = 7;
    localparam int OSC_PIN_LO = 6;
    localparam int PIN_WAKE = 0;
    localparam int PIN_REF_OUT = 2;
    localparam int PIN_INPUT_ONLY = 3;
    localparam int PIN_TMR_CLK = 4;
    localparam int PIN_SLAVE_SEL = 5;
    // Reset values
    localparam logic [7:0] RST_ANALOG_SELECT = 8'hFF;
    localparam logic [7:0] RST_DIRECTION = 8'hFF;
    localparam logic [7:0] RST_LATCH = 8'h00;
    localparam logic [7:0] RST_ZERO = 8'h00;
    // Channels present on the small package
    localparam logic [7:0] SMALL_PKG_MASK = 8'h1F;
    localparam logic [7:0] FULL_PKG_MASK = 8'hFF;
    localparam logic [7:0] OSC_PINS_MASK = 8'hC0;
    localparam logic [12:0] INT_VECTOR = 13'h0004;
    localparam int SYNC_STAGES = 2;
endpackage : pasw_pkg

// >>> core/pasw_sync.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Two flip-flop synchroniser
// ****************************************
module pasw_sync
#(
    parameter int W = 8
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta_q <= '0;
            sync_q <= '0;
        end
        else
        begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;
endmodule : pasw_sync
`default_nettype wire

// >>> core/pasw_top.sv
`timescale 1ns/100ps
`default_nettype none
// Operation
// - Analog pins read zero through port
// - Analog select leaves output drive alone
// - One analog bit per channel, 1=analog
// - Analog mode kills digital input features except the pin zero wake
// - Small package ignores channels seven to five
// - Wake enable switches pin zero sink
// - Pin zero low raises wake interrupt
// - Global enable vectors to 0004h
// - Pin zero: port, converter, comparators, wake
// - Pin two: port, converter, reference functions
// - Pin three is input only
// - Pin four: port, timer clock, comparator
// - Pin five: port, converter, select, comparator
// - Pins six, seven: port or oscillator
// - Direction one disables driver, zero drives
// - Crystal oscillator mode reads direction seven, six high
module pasw_top
    import pasw_pkg::*;
#(
    parameter bit SMALL_PACKAGE = 1'b0
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    output logic [DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] pin_in,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe,
    output logic [7:0] analog_switch_en,
    output logic [7:0] digital_input_en,
    output logic slow_discharge_sink_en,
    input wire logic crystal_osc_mode,
    input wire logic clock_out_en,
    input wire logic clock_out_level,
    input wire logic comparator_one_out,
    input wire logic comparator_one_out_en,
    input wire logic comparator_two_out,
    input wire logic comparator_two_out_en,
    input wire logic comparator_ref_voltage_en,
    output logic timer_zero_clock_in,
    output logic slave_select_n,
    output logic irq,
    output logic wake_request,
    output logic vector_request,
    output logic [12:0] vector_address
);
    // ****************************************
    // Bus decode
    // ****************************************
    logic setup_phase;
    logic access_wr;
    logic hit_analog_select;
    logic hit_power_control;
    logic hit_pins;
    logic hit_dir;
    logic hit_flag;
    logic hit_mask;
    logic hit_int_control;
    logic addr_mapped;

    assign setup_phase = psel & ~penable;
    assign access_wr = psel & penable & pwrite;
    assign hit_analog_select = (paddr == OFF_ANALOG_SELECT);
    assign hit_power_control = (paddr == OFF_POWER_CONTROL);
    assign hit_pins = (paddr == OFF_PORT_PINS);
    assign hit_dir = (paddr == OFF_PORT_DIRECTION);
    assign hit_flag = (paddr == OFF_INT_FLAG_TWO);
    assign hit_mask = (paddr == OFF_INT_ENABLE_TWO);
    assign hit_int_control = (paddr == OFF_INT_CONTROL);
    assign addr_mapped = hit_analog_select | hit_power_control | hit_pins | hit_dir
                       | hit_flag | hit_mask | hit_int_control;

    // Zero wait states: answer in the access phase
    assign pready = psel & penable;
    assign pslverr = psel & penable & ~addr_mapped;

    // ****************************************
    // Registers
    // ****************************************
    logic [7:0] analog_select_q;
    logic [7:0] latch_q;
    logic [7:0] dir_q;
    logic wake_en_q;
    logic sw_bor_q;
    logic [7:0] flag_q;
    logic [7:0] flag_d;
    logic [7:0] mask_q;
    logic [1:0] int_control_q;
    logic [7:0] wdata8;
    logic [7:0] impl_mask;

    assign wdata8 = pwdata[7:0];
    assign impl_mask = SMALL_PACKAGE ? SMALL_PKG_MASK : FULL_PKG_MASK;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            analog_select_q <= RST_ANALOG_SELECT;
            latch_q <= RST_LATCH;
            dir_q <= RST_DIRECTION;
            mask_q <= RST_ZERO;
            wake_en_q <= 1'b0;
            sw_bor_q <= 1'b0;
            int_control_q <= 2'h0;
        end
        else if (access_wr)
        begin
            if (hit_analog_select)
                analog_select_q <= wdata8 & impl_mask;
            if (hit_pins)
                latch_q <= wdata8;
            if (hit_dir)
                dir_q <= wdata8;
            if (hit_mask)
                mask_q <= wdata8;
            if (hit_power_control)
            begin
                wake_en_q <= wdata8[POWER_CONTROL_WAKE_EN_BIT];
                sw_bor_q <= wdata8[POWER_CONTROL_SW_BOR_BIT];
            end
            if (hit_int_control)
                int_control_q <= {wdata8[INT_CONTROL_GLOBAL_BIT], wdata8[INT_CONTROL_PERIPH_BIT]};
        end
    end

    // ****************************************
    // Pin input path
    // ****************************************
    logic [7:0] pins_sync;
    logic [7:0] analog_eff;
    logic [7:0] pins_read;

    pasw_sync #(.W(8)) u_pin_sync
    (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(pin_in),
        .sync_out(pins_sync)
    );

    assign analog_eff = analog_select_q & impl_mask;
    assign analog_switch_en = analog_eff;
    assign digital_input_en = ~analog_eff;
    assign pins_read = pins_sync & digital_input_en;
    assign timer_zero_clock_in = pins_read[PIN_TMR_CLK];
    assign slave_select_n = ~digital_input_en[PIN_SLAVE_SEL]
                          | pins_read[PIN_SLAVE_SEL];

    // ****************************************
    // Pin output path
    // ****************************************
    logic [7:0] drive_val;
    logic [7:0] drive_en;
    logic [7:0] osc_gate;
    logic [7:0] dir_read;

    assign osc_gate = crystal_osc_mode ? ~OSC_PINS_MASK : FULL_PKG_MASK;

    // Driver follows direction and peripheral overrides, never analog select
    always_comb
    begin
        drive_val = latch_q;
        drive_en = ~dir_q;
        if (comparator_one_out_en)
        begin
            drive_val[PIN_TMR_CLK] = comparator_one_out;
            drive_en[PIN_TMR_CLK] = 1'b1;
        end
        if (comparator_two_out_en)
        begin
            drive_val[PIN_SLAVE_SEL] = comparator_two_out;
            drive_en[PIN_SLAVE_SEL] = 1'b1;
        end
        if (comparator_ref_voltage_en)
            drive_en[PIN_REF_OUT] = 1'b0;
        drive_en[PIN_INPUT_ONLY] = 1'b0;
        if (clock_out_en && !crystal_osc_mode)
        begin
            drive_val[OSC_PIN_LO] = clock_out_level;
            drive_en[OSC_PIN_LO] = 1'b1;
            drive_en[OSC_PIN_HI] = 1'b0;
        end
        drive_en = drive_en & osc_gate;
    end

    assign pin_out = drive_val;
    assign pin_oe = drive_en;
    assign dir_read = crystal_osc_mode ? (dir_q | OSC_PINS_MASK) : dir_q;

    // ****************************************
    // Slow discharge wake
    // ****************************************
    logic below_now;
    logic below_q;
    logic wake_event;

    assign slow_discharge_sink_en = wake_en_q;
    assign below_now = wake_en_q & ~pins_sync[PIN_WAKE];
    assign wake_event = below_now & ~below_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            below_q <= 1'b0;
        else
            below_q <= below_now;
    end

    // ****************************************
    // Interrupt status
    // ****************************************
    logic [7:0] clr_bits;
    logic [7:0] set_bits;

    assign clr_bits = (access_wr && hit_flag) ? wdata8 : RST_ZERO;
    assign set_bits = {1'b0, wake_event, 6'h00};
    // Set wins over a write-one clear in the same cycle
    assign flag_d = (flag_q & ~clr_bits) | set_bits;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            flag_q <= RST_ZERO;
        else
            flag_q <= flag_d;
    end

    assign irq = |(flag_q & mask_q);
    assign wake_request = irq;
    assign vector_request = irq & int_control_q[1];
    assign vector_address = INT_VECTOR;

    // ****************************************
    // Read data
    // ****************************************
    logic [7:0] rd_mux;
    logic [7:0] power_control_read;

    assign power_control_read = {2'b00, wake_en_q, sw_bor_q, 4'h0};
    assign rd_mux = hit_analog_select ? analog_eff :
                    hit_power_control ? power_control_read :
                    hit_pins ? pins_read :
                    hit_dir ? dir_read :
                    hit_flag ? flag_q :
                    hit_mask ? mask_q :
                    hit_int_control ? {int_control_q, 6'h00} : RST_ZERO;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= '0;
        else if (setup_phase)
            prdata <= {24'h000000, rd_mux};
    end

    // ****************************************
    // Checks
    // ****************************************
    a_analog_reads_zero: assert property (@(posedge pclk) disable iff (!presetn)
        setup_phase && !pwrite && hit_pins
        |=> (prdata[7:0] & analog_eff) == 8'h00)
        else $error("analog pin read nonzero");

    a_drive_follows_dir: assert property (@(posedge pclk) disable iff (!presetn)
        (!crystal_osc_mode && !clock_out_en && !comparator_one_out_en)
        |-> (pin_oe[1:0] == ~dir_q[1:0]))
        else $error("driver does not follow direction");

    a_analog_keeps_out: assert property (@(posedge pclk) disable iff (!presetn)
        (!dir_q[1] && analog_eff[1]) |-> (pin_oe[1] && pin_out[1] == latch_q[1]))
        else $error("analog select changed output");

    a_input_only_pin: assert property (@(posedge pclk) disable iff (!presetn)
        !pin_oe[PIN_INPUT_ONLY])
        else $error("input-only pin driven");

    a_small_pkg_bits: assert property (@(posedge pclk) disable iff (!presetn)
        SMALL_PACKAGE |-> analog_eff[7:5] == 3'b000)
        else $error("missing channels took effect");

    a_osc_dir_read: assert property (@(posedge pclk) disable iff (!presetn)
        setup_phase && !pwrite && hit_dir && crystal_osc_mode
        |=> prdata[7:6] == 2'b11)
        else $error("direction bits 7:6 not one");

    a_wake_sets_flag: assert property (@(posedge pclk) disable iff (!presetn)
        wake_event |=> flag_q[FLAG_WAKE_BIT] ##1 flag_q[FLAG_WAKE_BIT]
        || $past(access_wr && hit_flag && pwdata[FLAG_WAKE_BIT]))
        else $error("wake flag lost");

    a_pin_low_wakes: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(below_now) && mask_q[FLAG_WAKE_BIT] |=> wake_request)
        else $error("no wake on low pin");

    a_vector_gated: assert property (@(posedge pclk) disable iff (!presetn)
        vector_request |-> int_control_q[1] && vector_address == 13'h0004)
        else $error("vector without global enable");

    a_sink_follows_en: assert property (@(posedge pclk) disable iff (!presetn)
        access_wr && hit_power_control |=> slow_discharge_sink_en == $past(pwdata[POWER_CONTROL_WAKE_EN_BIT]))
        else $error("sink does not follow enable");
endmodule : pasw_top
`default_nettype wire

// >>> tb/pasw_rc_model.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// External capacitor on pin zero
// ****************************************
module pasw_rc_model
#(
    parameter int FULL = 40,
    parameter int THRESH = 10
)
(
    input wire logic pclk,
    input wire logic drive_en,
    input wire logic drive_val,
    input wire logic sink_en,
    output logic pin_level
);
    int charge = 0;

    // Driven pin sets the charge at once, sink drains one step a cycle
    always @(posedge pclk)
    begin
        if (drive_en)
            charge <= drive_val ? FULL : 0;
        else if (sink_en && charge > 0)
            charge <= charge - 1;
    end

    assign pin_level = (charge > THRESH);
endmodule : pasw_rc_model
`default_nettype wire

// >>> tb/pasw_top_tb.sv
`timescale 1ns/100ps
`default_nettype none
module pasw_top_tb
    import pasw_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [DATA_W-1:0] pwdata = '0;
    logic [DATA_W-1:0] prdata;
    logic [DATA_W-1:0] rd;
    logic pready, pslverr, err, rc_lvl;
    logic [6:0] pin_hi = 7'h5F;
    logic xtal = 1'b0;
    logic c1 = 1'b0;
    logic c1_en = 1'b0;
    logic c2 = 1'b0;
    logic c2_en = 1'b0;
    logic vref_en = 1'b0;
    logic clko_en = 1'b0;
    logic clko_lvl = 1'b0;
    logic [7:0] pin_out, pin_oe, an_en, din_en, an_en_s;
    logic sink, tmr, ss_n, irq, wake, vreq;
    logic [12:0] vaddr;
    int miscompares = 0;
    int compares = 0;

    initial
    begin
        forever #50 pclk = ~pclk;
    end

    pasw_top #(.SMALL_PACKAGE(1'b0)) u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pin_in({pin_hi, rc_lvl}),
        .pin_out(pin_out), .pin_oe(pin_oe), .analog_switch_en(an_en),
        .digital_input_en(din_en), .slow_discharge_sink_en(sink),
        .crystal_osc_mode(xtal), .clock_out_en(clko_en), .clock_out_level(clko_lvl),
        .comparator_one_out(c1), .comparator_one_out_en(c1_en),
        .comparator_two_out(c2), .comparator_two_out_en(c2_en),
        .comparator_ref_voltage_en(vref_en), .timer_zero_clock_in(tmr),
        .slave_select_n(ss_n), .irq(irq), .wake_request(wake),
        .vector_request(vreq), .vector_address(vaddr)
    );

    // Small package: channels seven to five missing
    pasw_top #(.SMALL_PACKAGE(1'b1)) u_small (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(),
        .pready(), .pslverr(), .pin_in({pin_hi, rc_lvl}),
        .pin_out(), .pin_oe(), .analog_switch_en(an_en_s),
        .digital_input_en(), .slow_discharge_sink_en(),
        .crystal_osc_mode(xtal), .clock_out_en(clko_en), .clock_out_level(clko_lvl),
        .comparator_one_out(c1), .comparator_one_out_en(c1_en),
        .comparator_two_out(c2), .comparator_two_out_en(c2_en),
        .comparator_ref_voltage_en(vref_en), .timer_zero_clock_in(),
        .slave_select_n(), .irq(), .wake_request(),
        .vector_request(), .vector_address()
    );

    pasw_rc_model u_rc (
        .pclk(pclk), .drive_en(pin_oe[0]), .drive_val(pin_out[0]),
        .sink_en(sink), .pin_level(rc_lvl)
    );

    // ****************************************
    // Bus access and checking
    // ****************************************
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
        begin
            miscompares++;
            $display("ERROR %0t: no pready", $time);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge pclk);
    endtask : apb

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            miscompares++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp

    task automatic conclude();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : conclude

    initial
    begin
        #(3000 * 100);
        miscompares++;
        conclude();
    end

    // ****************************************
    // Tests
    // ****************************************
    initial
    begin
        int n;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, OFF_ANALOG_SELECT, 0);
        cmp(rd, 32'h0000_00FF);
        apb(0, OFF_PORT_DIRECTION, 0);
        cmp(rd, 32'h0000_00FF);
        apb(0, OFF_PORT_PINS, 0);
        cmp(rd, 0);
        cmp(ss_n, 1);
        cmp(din_en, 0);
        cmp(pin_oe, 0);
        cmp(tmr, 0);
        cmp(an_en_s, 8'h1F);
        $display("test reset done");
        apb(1, OFF_ANALOG_SELECT, 32'h0000_000F);
        apb(0, OFF_PORT_PINS, 0);
        cmp(rd, 32'h0000_00B0);
        cmp(din_en, 8'hF0);
        cmp(an_en, 8'h0F);
        cmp(tmr, 1);
        cmp(ss_n, 1);
        cmp(an_en_s, 8'h0F);
        @(posedge pclk);
        pin_hi <= 7'h4F;
        repeat (3) @(posedge pclk);
        @(negedge pclk);
        cmp(ss_n, 0);
        apb(0, OFF_PORT_PINS, 0);
        cmp(rd, 32'h0000_0090);
        $display("test analog read done");
        @(posedge pclk);
        c1 <= 1'b1;
        c1_en <= 1'b1;
        c2 <= 1'b0;
        c2_en <= 1'b1;
        vref_en <= 1'b1;
        apb(1, OFF_ANALOG_SELECT, 32'h0000_00FF);
        cmp(an_en_s, 8'h1F);
        apb(1, OFF_PORT_PINS, 32'h0000_00A5);
        apb(1, OFF_PORT_DIRECTION, 0);
        cmp(pin_oe, 8'hF3);
        cmp(pin_out & 8'hF7, 8'h95);
        apb(0, OFF_PORT_PINS, 0);
        cmp(rd, 0);
        @(posedge pclk);
        xtal <= 1'b1;
        apb(0, OFF_PORT_DIRECTION, 0);
        cmp(rd, 32'h0000_00C0);
        cmp(pin_oe, 8'h33);
        @(posedge pclk);
        xtal <= 1'b0;
        clko_en <= 1'b1;
        clko_lvl <= 1'b1;
        @(negedge pclk);
        cmp(pin_oe, 8'h73);
        cmp(pin_out & 8'hF7, 8'hD5);
        @(posedge pclk);
        clko_en <= 1'b0;
        c1_en <= 1'b0;
        c2_en <= 1'b0;
        vref_en <= 1'b0;
        $display("test drive done");
        apb(1, OFF_INT_FLAG_TWO, 32'h0000_0040);
        apb(1, OFF_PORT_DIRECTION, 32'h0000_00FF);
        apb(1, OFF_ANALOG_SELECT, 0);
        apb(1, OFF_INT_ENABLE_TWO, 32'h0000_0040);
        apb(1, OFF_INT_CONTROL, 32'h0000_00C0);
        apb(1, OFF_POWER_CONTROL, 32'h0000_0020);
        cmp(sink, 1);
        cmp(irq, 0);
        for (n = 0; n < 200 && irq !== 1'b1; n++)
            @(negedge pclk);
        cmp(irq, 1);
        cmp(wake, 1);
        cmp(vreq, 1);
        cmp(vaddr, 13'h0004);
        apb(1, OFF_INT_ENABLE_TWO, 0);
        cmp(irq, 0);
        apb(0, OFF_INT_FLAG_TWO, 0);
        cmp(rd, 32'h0000_0040);
        apb(1, OFF_POWER_CONTROL, 0);
        cmp(sink, 0);
        apb(1, OFF_INT_FLAG_TWO, 32'h0000_0040);
        apb(0, OFF_INT_FLAG_TWO, 0);
        cmp(rd, 0);
        $display("test wake done");
        apb(1, 8'h1C, 32'h0000_00FF);
        cmp(err, 1);
        apb(0, 8'h1C, 0);
        cmp(rd, 0);
        cmp(err, 1);
        $display("test unmapped done");
        conclude();
    end
endmodule : pasw_top_tb
`default_nettype wire
